/* File: mrs_pkg.sv */
// Constants and types of the Modbus RTU read-only status map.
// Assumes one 200 MHz clock and an RS485 transceiver outside.
package mrs_pkg;
  // Clock and default line setup
  localparam int CLK_HZ = 200_000_000;
  localparam int DEF_BAUD = 19200;
  localparam logic [7:0] DEF_NODE = 8'h01;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // Silence of 3.5 chars of 11 bits, rounded up, ends a frame
  localparam logic [5:0] GAP_BITS = 6'h27;
  // Character: start, 8 data, one stop; parity and 2nd stop add
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [7:0] RQ_LEN = 8'h08;
  localparam logic [7:0] RQ_MIN = 8'h04;
  // Function and exception codes
  localparam logic [7:0] FC_RD_BITS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] MAX_BITS = 16'h07d0;
  localparam logic [15:0] MAX_WORDS = 16'h007d;
  // Response lengths and layout
  localparam logic [7:0] EXC_LEN = 8'h05;
  localparam logic [7:0] BITS_LEN = 8'h06;
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [7:0] DATA_IDX = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // Single-bit input addresses
  localparam logic [15:0] BIT_SYS = 16'h0000;
  localparam logic [15:0] BIT_FLOW = 16'h0001;
  localparam logic [15:0] BIT_COMMS = 16'h0010;
  localparam logic [15:0] BIT_POT = 16'h0011;
  // Word addresses
  localparam logic [15:0] W_RUN = 16'h0000;
  localparam logic [15:0] W_CLK_Y = 16'h0020;
  localparam logic [15:0] W_CLK_MO = 16'h0021;
  localparam logic [15:0] W_CLK_D = 16'h0022;
  localparam logic [15:0] W_CLK_H = 16'h0023;
  localparam logic [15:0] W_CLK_MI = 16'h0024;
  localparam logic [15:0] W_CLK_S = 16'h0025;
  localparam logic [15:0] W_SAMPLE = 16'h0030;
  localparam logic [15:0] W_SVC_Y = 16'h0080;
  localparam logic [15:0] W_SVC_MO = 16'h0081;
  localparam logic [15:0] W_SVC_D = 16'h0082;
  localparam logic [15:0] W_ALARM = 16'h0200;
  // Run state codes
  localparam logic [15:0] RUN_OK = 16'h0000;
  localparam logic [15:0] RUN_MINOR = 16'h0001;
  localparam logic [15:0] RUN_STOP_FROZEN = 16'h0002;
  localparam logic [15:0] RUN_STOP_SAFE = 16'h0003;
  localparam logic [15:0] RUN_CRIT_FROZEN = 16'h0004;
  // Sample point codes; 1..4 select sample_point_n
  localparam logic [15:0] SP_IDLE = 16'h0000;
  localparam logic [15:0] SP_PURGE = 16'hffff;
  localparam logic [15:0] SP_MAIN_EXTERNAL_CELL = 16'h0101;
  localparam logic [15:0] SP_MAIN_EXTERNAL_CELL_PURGE = 16'hff01;
  localparam logic [15:0] SP_CAL_BOTTLE = 16'hac02;
  localparam logic [15:0] SP_CAL_PURGE = 16'hacff;
  // Alarm state bits, combined
  localparam logic [15:0] ALM_TRIGGERED = 16'h0001;
  localparam logic [15:0] ALM_RECOVERING = 16'h0002;
  localparam logic [15:0] ALM_LATCHED = 16'h0004;
  localparam logic [15:0] ALM_MUTED = 16'h0008;

  // Line settings
  typedef struct packed {
    logic [7:0] node;
    logic [15:0] bit_cycles;
    logic [1:0] parity;
    logic two_stop;
    logic term_on;
  } mrs_cfg_t;

  // Live status from the analyser
  typedef struct packed {
    logic system_fault_bit;
    logic flow_fail_bit;
    logic comms_error_bit;
    logic catchpot_full_bit;
    logic [15:0] run_state_word;
    logic [5:0][15:0] clock_words;
    logic [15:0] active_sample_point;
    logic [2:0][15:0] service_due_words;
    logic [15:0] first_alarm_state;
  } mrs_status_t;

  typedef enum logic [0:0] {RX_IDLE, RX_BITS} mrs_rx_state_t;
  typedef enum logic [0:0] {M_COLLECT, M_SEND} mrs_main_state_t;
endpackage

/* File: mrs_slave.sv */
// Modbus RTU slave serving the analyser's read-only status map.
// Assumes a half-duplex RS485 transceiver on line_* and inputs
// synchronous to mclk_i.
//
// Operation
// (R1) Slave only; replies to addressed frames only
// (R2) Defaults: node 1, 19200, even, 1 stop
// (R3) Node, baud, parity, termination loadable at run time
// (R4) Inputs 0/1: system fault, flow fail
// (R5) Inputs 10h/11h: comms error, catchpot full
// (R6) Word 0 carries run state code
// (R7) Words 20h-25h clock, 80h-82h service due
// (R8) Word 30h carries sample point code
// (R9) Word 200h carries combined alarm state
// (R10) Unmapped read gives illegal address exception
// (R11) Writes answered with exception, nothing stored
`timescale 1ns/100ps
module mrs_slave #(
  parameter logic [15:0] BIT_CYCLES_DEF = 16'(mrs_pkg::CLK_HZ / mrs_pkg::DEF_BAUD)
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic line_rx_i,
  output logic line_tx_o,
  output logic line_oe_o,
  output logic term_en_o,
  input wire logic cfg_load_i,
  input wire mrs_pkg::mrs_cfg_t cfg_i,
  input wire mrs_pkg::mrs_status_t status_i,
  output mrs_pkg::mrs_cfg_t cfg_o,
  output logic frame_ok_o
);
  // Whole module state
  typedef struct packed {
    mrs_pkg::mrs_cfg_t cfg;
    mrs_pkg::mrs_rx_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [11:0] rx_bits;
    logic [15:0] gap_cnt;
    logic [5:0] gap_bits;
    logic [7:0][7:0] rq;
    logic [7:0] rq_cnt;
    logic rq_err;
    logic [15:0] rq_crc;
    mrs_pkg::mrs_main_state_t mst;
    logic [7:0] fc;
    logic [7:0] exc;
    logic [15:0] start;
    logic [15:0] qty;
    logic [7:0] tx_len;
    logic [7:0] tx_idx;
    logic [15:0] tx_crc;
    logic [11:0] tx_sr;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic ok_pulse;
  } mrs_state_t;

  mrs_state_t st;
  mrs_state_t next_st;

  // One CRC-16 step over a byte, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ mrs_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Parity bit for a byte
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] mode);
    return (mode == mrs_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction

  // Last mapped word of the block holding addr; bit 16 flags a hit
  function automatic logic [16:0] word_end(input logic [15:0] a);
    logic [16:0] r;
    r = '0;
    if (a == mrs_pkg::W_RUN)
      r = {1'b1, mrs_pkg::W_RUN};
    else if (a >= mrs_pkg::W_CLK_Y && a <= mrs_pkg::W_CLK_S)
      r = {1'b1, mrs_pkg::W_CLK_S};
    else if (a == mrs_pkg::W_SAMPLE)
      r = {1'b1, mrs_pkg::W_SAMPLE};
    else if (a >= mrs_pkg::W_SVC_Y && a <= mrs_pkg::W_SVC_D)
      r = {1'b1, mrs_pkg::W_SVC_D};
    else if (a == mrs_pkg::W_ALARM)
      r = {1'b1, mrs_pkg::W_ALARM};
    return r;
  endfunction

  // Word value at a mapped address
  function automatic logic [15:0] word_at(input mrs_pkg::mrs_status_t s, input logic [15:0] a);
    logic [15:0] w;
    w = '0;
    if (a == mrs_pkg::W_RUN)
      w = s.run_state_word; // see (R6)
    else if (a >= mrs_pkg::W_CLK_Y && a <= mrs_pkg::W_CLK_S)
      w = s.clock_words[3'(a - mrs_pkg::W_CLK_Y)]; // see (R7)
    else if (a == mrs_pkg::W_SAMPLE)
      w = s.active_sample_point; // see (R8)
    else if (a >= mrs_pkg::W_SVC_Y && a <= mrs_pkg::W_SVC_D)
      w = s.service_due_words[2'(a - mrs_pkg::W_SVC_Y)]; // see (R7)
    else if (a == mrs_pkg::W_ALARM)
      w = s.first_alarm_state; // see (R9)
    return w;
  endfunction

  // Single-bit input at an address
  function automatic logic bit_at(input mrs_pkg::mrs_status_t s, input logic [15:0] a);
    unique case (a)
      mrs_pkg::BIT_SYS: return s.system_fault_bit; // see (R4)
      mrs_pkg::BIT_FLOW: return s.flow_fail_bit; // see (R4)
      mrs_pkg::BIT_COMMS: return s.comms_error_bit; // see (R5)
      mrs_pkg::BIT_POT: return s.catchpot_full_bit; // see (R5)
      default: return 1'b0;
    endcase
  endfunction

  // Next state
  always_comb
  begin
    logic [11:0] nb;
    logic [7:0] d;
    logic [3:0] nbits;
    logic [16:0] last;
    logic [16:0] blk;
    logic [7:0] tb;
    logic [11:0] fr;
    nb = '0;
    d = '0;
    last = '0;
    blk = '0;
    tb = '0;
    fr = '1;
    next_st = st;
    next_st.ok_pulse = 1'b0;
    nbits = mrs_pkg::CHAR_BITS + 4'(st.cfg.parity != mrs_pkg::PAR_NONE);

    // Run-time line setup; takes effect at once, so load between frames
    if (cfg_load_i)
      next_st.cfg = cfg_i; // see (R3)

    // Receiver; echo ignored while answering
    unique case (st.rx_st)
      mrs_pkg::RX_IDLE:
      begin
        if (st.rq_cnt != '0 && st.gap_bits != mrs_pkg::GAP_BITS)
        begin
          if (st.gap_cnt >= st.cfg.bit_cycles - 16'h0001)
          begin
            next_st.gap_cnt = '0;
            next_st.gap_bits = st.gap_bits + 6'h01;
          end
          else
            next_st.gap_cnt = st.gap_cnt + 16'h0001;
        end
        if (!line_rx_i && st.mst == mrs_pkg::M_COLLECT)
        begin
          next_st.rx_st = mrs_pkg::RX_BITS;
          next_st.rx_cnt = st.cfg.bit_cycles >> 1;
          next_st.rx_idx = '0;
        end
      end
      mrs_pkg::RX_BITS:
      begin
        next_st.gap_cnt = '0;
        next_st.gap_bits = '0;
        if (st.rx_cnt != '0)
          next_st.rx_cnt = st.rx_cnt - 16'h0001;
        else
        begin
          nb = st.rx_bits;
          nb[st.rx_idx] = line_rx_i;
          next_st.rx_bits = nb;
          next_st.rx_cnt = st.cfg.bit_cycles - 16'h0001;
          next_st.rx_idx = st.rx_idx + 4'h1;
          // A high start sample is a glitch, not a character
          if (st.rx_idx == '0 && line_rx_i)
            next_st.rx_st = mrs_pkg::RX_IDLE;
          else if (st.rx_idx == nbits - 4'h1)
          begin
            next_st.rx_st = mrs_pkg::RX_IDLE;
            d = nb[8:1];
            if (st.rq_cnt < mrs_pkg::RQ_LEN)
              next_st.rq[3'(st.rq_cnt)] = d;
            if (st.rq_cnt != '1)
              next_st.rq_cnt = st.rq_cnt + 8'h01;
            next_st.rq_crc = crc_step(st.rq_crc, d);
            // Parity or stop error spoils the whole frame
            if (!line_rx_i || (st.cfg.parity != mrs_pkg::PAR_NONE && nb[9] != par_of(d, st.cfg.parity)))
              next_st.rq_err = 1'b1;
          end
        end
      end
    endcase

    // Frame closed by silence: decode and queue an answer
    if (st.rx_st == mrs_pkg::RX_IDLE && st.rq_cnt != '0 && st.gap_bits == mrs_pkg::GAP_BITS)
    begin
      next_st.rq_cnt = '0;
      next_st.rq_err = 1'b0;
      next_st.rq_crc = mrs_pkg::CRC_INIT;
      next_st.gap_bits = '0;
      next_st.gap_cnt = '0;
      // Only frames to our own node; broadcasts get no reply
      if (!st.rq_err && st.rq_cnt >= mrs_pkg::RQ_MIN && st.rq_crc == '0 && st.rq[0] == st.cfg.node) // see (R1)
      begin
        next_st.ok_pulse = 1'b1;
        next_st.fc = st.rq[1];
        next_st.start = {st.rq[2], st.rq[3]};
        next_st.qty = {st.rq[4], st.rq[5]};
        next_st.exc = mrs_pkg::EXC_NONE;
        next_st.tx_idx = '0;
        next_st.tx_crc = mrs_pkg::CRC_INIT;
        next_st.mst = mrs_pkg::M_SEND;
        last = {1'b0, next_st.start} + {1'b0, next_st.qty} - 17'h00001;
        blk = word_end(next_st.start);
        if (st.rq[1] == mrs_pkg::FC_RD_BITS && st.rq_cnt == mrs_pkg::RQ_LEN)
        begin
          if (next_st.qty == '0 || next_st.qty > mrs_pkg::MAX_BITS)
            next_st.exc = mrs_pkg::EXC_VALUE;
          else if (!((next_st.start <= mrs_pkg::BIT_FLOW && last <= {1'b0, mrs_pkg::BIT_FLOW})
                   || (next_st.start >= mrs_pkg::BIT_COMMS && last <= {1'b0, mrs_pkg::BIT_POT})))
            next_st.exc = mrs_pkg::EXC_ADDR; // see (R10)
        end
        else if ((st.rq[1] == mrs_pkg::FC_RD_INPUT || st.rq[1] == mrs_pkg::FC_RD_HOLD)
                 && st.rq_cnt == mrs_pkg::RQ_LEN)
        begin
          if (next_st.qty == '0 || next_st.qty > mrs_pkg::MAX_WORDS)
            next_st.exc = mrs_pkg::EXC_VALUE;
          else if (!blk[16] || last > {1'b0, blk[15:0]})
            next_st.exc = mrs_pkg::EXC_ADDR; // see (R10)
        end
        else
          next_st.exc = mrs_pkg::EXC_FUNC; // see (R11)
        if (next_st.exc != mrs_pkg::EXC_NONE)
          next_st.tx_len = mrs_pkg::EXC_LEN;
        else if (st.rq[1] == mrs_pkg::FC_RD_BITS)
          next_st.tx_len = mrs_pkg::BITS_LEN;
        else
          next_st.tx_len = mrs_pkg::HDR_LEN + 8'(next_st.qty << 1);
      end
    end

    // Transmit bit engine
    if (st.tx_left != '0)
    begin
      if (st.tx_cnt == '0)
      begin
        next_st.tx_sr = {1'b1, st.tx_sr[11:1]};
        next_st.tx_left = st.tx_left - 4'h1;
        next_st.tx_cnt = st.cfg.bit_cycles - 16'h0001;
      end
      else
        next_st.tx_cnt = st.tx_cnt - 16'h0001;
    end
    else if (st.mst == mrs_pkg::M_SEND)
    begin
      if (st.tx_idx == st.tx_len)
        next_st.mst = mrs_pkg::M_COLLECT;
      else
      begin
        // Response byte by position; data read live from status
        if (st.tx_idx == st.tx_len - 8'h02)
          tb = st.tx_crc[7:0];
        else if (st.tx_idx == st.tx_len - 8'h01)
          tb = st.tx_crc[15:8];
        else if (st.tx_idx == '0)
          tb = st.cfg.node;
        else if (st.tx_idx == 8'h01)
          tb = (st.exc != mrs_pkg::EXC_NONE) ? (st.fc | mrs_pkg::EXC_FLAG) : st.fc;
        else if (st.exc != mrs_pkg::EXC_NONE)
          tb = st.exc; // see (R11)
        else if (st.tx_idx == 8'h02)
          tb = (st.fc == mrs_pkg::FC_RD_BITS) ? 8'h01 : 8'(st.qty << 1);
        else if (st.fc == mrs_pkg::FC_RD_BITS)
          tb = {6'h00, (st.qty > 16'h0001) && bit_at(status_i, st.start + 16'h0001), bit_at(status_i, st.start)};
        else
        begin
          last[15:0] = word_at(status_i, st.start + 16'({8'h00, st.tx_idx - mrs_pkg::DATA_IDX} >> 1));
          tb = (st.tx_idx[0]) ? last[15:8] : last[7:0];
        end
        if (st.tx_idx < st.tx_len - 8'h02)
          next_st.tx_crc = crc_step(st.tx_crc, tb);
        fr = {3'b111, tb, 1'b0};
        if (st.cfg.parity != mrs_pkg::PAR_NONE)
          fr[9] = par_of(tb, st.cfg.parity);
        next_st.tx_sr = fr;
        next_st.tx_left = nbits + 4'(st.cfg.two_stop);
        next_st.tx_cnt = st.cfg.bit_cycles - 16'h0001;
        next_st.tx_idx = st.tx_idx + 8'h01;
      end
    end
  end

  // State register; defaults give the stock line setup
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.cfg.node <= mrs_pkg::DEF_NODE; // see (R2)
      st.cfg.bit_cycles <= BIT_CYCLES_DEF; // see (R2)
      st.cfg.parity <= mrs_pkg::PAR_EVEN; // see (R2)
      st.rq_crc <= mrs_pkg::CRC_INIT;
      st.tx_crc <= mrs_pkg::CRC_INIT;
      st.tx_sr <= '1;
      st.rx_st <= mrs_pkg::RX_IDLE;
      st.mst <= mrs_pkg::M_COLLECT;
    end
    else
      st <= next_st;
  end

  // Driver enabled only while answering
  assign line_oe_o = (st.mst == mrs_pkg::M_SEND); // see (R1)
  assign line_tx_o = st.tx_sr[0];
  assign term_en_o = st.cfg.term_on; // see (R3)
  assign cfg_o = st.cfg;
  assign frame_ok_o = st.ok_pulse;
endmodule

/* File: mrs_checker.sv */
// Checker for the Modbus status map slave: line timing and settings.
// Assumes bind onto mrs_slave; one clock, reset async high.
`timescale 1ns/100ps
module mrs_checker #(
  parameter logic [15:0] BIT_CYCLES_DEF = 16'(mrs_pkg::CLK_HZ / mrs_pkg::DEF_BAUD)
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic line_rx_i,
  input wire logic line_tx_o,
  input wire logic line_oe_o,
  input wire logic cfg_load_i,
  input wire mrs_pkg::mrs_cfg_t cfg_i,
  input wire mrs_pkg::mrs_cfg_t cfg_o,
  input wire logic frame_ok_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Start bit of the reply, held low
  sequence s_start;
    (!line_tx_o) [*8];
  endsequence
  // Accept pulse with driver on, then the start bit
  sequence s_accept;
    frame_ok_o && line_oe_o;
  endsequence
  property p_oe_rise;
    $rose(line_oe_o) |-> frame_ok_o;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("driver on without accepted frame");
  property p_start;
    frame_ok_o |-> s_accept ##1 s_start;
  endproperty
  a_start: assert property (p_start) else $error("reply start bit late");
  property p_tx_idle;
    !line_oe_o |-> line_tx_o;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit low while driver off");
  // Frame closes only after a quiet line
  property p_quiet;
    frame_ok_o |-> $past(line_rx_i) && $past(line_rx_i, 8);
  endproperty
  a_quiet: assert property (p_quiet) else $error("frame accepted on a busy line");
  // Last stop bit stands before the driver lets go
  property p_stop;
    $fell(line_oe_o) |-> $past(line_tx_o) && $past(line_tx_o, 8);
  endproperty
  a_stop: assert property (p_stop) else $error("driver released inside a character");
  property p_dflt;
    $fell(rst_i) |-> cfg_o == {8'h01, BIT_CYCLES_DEF, mrs_pkg::PAR_EVEN, 2'h0};
  endproperty
  a_dflt: assert property (p_dflt) else $error("line settings not at defaults");
  property p_cfg_load;
    cfg_load_i |=> cfg_o == $past(cfg_i);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("settings not loaded");
  property p_cfg_hold;
    !cfg_load_i |=> $stable(cfg_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed unasked");
endmodule
bind mrs_slave mrs_checker #(.BIT_CYCLES_DEF(BIT_CYCLES_DEF)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .line_rx_i(line_rx_i), .line_tx_o(line_tx_o), .line_oe_o(line_oe_o), .cfg_load_i(cfg_load_i),
  .cfg_i(cfg_i), .cfg_o(cfg_o), .frame_ok_o(frame_ok_o));

/* File: mrs_master.sv */
// Modbus RTU master model on the slave's serial line.
// Assumes a parity bit, even unless odd is set; BIT_CYC clocks per bit.
`timescale 1ns/100ps
module mrs_master #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk_i,
  input wire logic tx_i,
  input wire logic oe_i,
  output logic rx_o
);
  logic [7:0] rx_q[$]; // Reply characters
  logic fmt_err = 1'b0; // Bad parity or stop seen
  logic odd = 1'b0; // Odd parity, set by the bench to match the slave
  initial rx_o = 1'b1; // Idle line is high
  // One character, LSB first; parity per odd, always one stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b ^ odd, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(negedge mclk_i);
      rx_o = f[i];
      repeat (BIT_CYC - 1) @(negedge mclk_i);
    end
  endtask
  // Mid-bit sampling of the reply while the driver is on
  always
  begin : rx_proc
    logic [7:0] d;
    @(negedge mclk_i);
    if (oe_i && !tx_i)
    begin
      repeat (BIT_CYC / 2) @(negedge mclk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(negedge mclk_i);
        d[i] = tx_i;
      end
      repeat (BIT_CYC) @(negedge mclk_i);
      fmt_err = fmt_err | (tx_i !== (^d ^ odd));
      repeat (BIT_CYC) @(negedge mclk_i);
      fmt_err = fmt_err | (tx_i !== 1'b1);
      rx_q.push_back(d);
    end
  end
endmodule

/* File: tb.sv */
// Testbench of the status map slave, polled by the master model.
// Assumes 16 clocks per bit so frames stay short.
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] BC = 16'h0010;
  typedef logic [7:0] mrs_tbq_t[$];
  logic mclk_i, rst_i, line_rx_i, line_tx_o, line_oe_o, term_en_o, cfg_load_i, frame_ok_o;
  mrs_pkg::mrs_cfg_t cfg_i, cfg_o;
  mrs_pkg::mrs_status_t status_i;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  int frames_ok = 0; // Accepted-frame pulses seen
  mrs_tbq_t rsp; // Last reply
  mrs_slave #(.BIT_CYCLES_DEF(BC)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .line_rx_i(line_rx_i),
    .line_tx_o(line_tx_o), .line_oe_o(line_oe_o), .term_en_o(term_en_o), .cfg_load_i(cfg_load_i),
    .cfg_i(cfg_i), .status_i(status_i), .cfg_o(cfg_o), .frame_ok_o(frame_ok_o));
  mrs_master #(.BIT_CYC(16)) u_mst (.mclk_i(mclk_i), .tx_i(line_tx_o), .oe_i(line_oe_o), .rx_o(line_rx_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Count accept pulses away from the edge that launches them
  always @(negedge mclk_i)
  begin
    if (frame_ok_o === 1'b1)
      frames_ok++;
  end
  // Hang guard, only a little above the longest run
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Independent CRC, low byte sent first
  function automatic logic [15:0] crc16(input mrs_tbq_t q);
    logic [15:0] c;
    c = mrs_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ mrs_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // Send a request and wait for the reply to end, or for silence
  task automatic run(input mrs_tbq_t q);
    logic [15:0] c;
    logic s;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    u_mst.rx_q.delete();
    foreach (q[i]) u_mst.send_byte(q[i]);
    s = 1'b0;
    for (int n = 0; n < 6000 && !(s && line_oe_o === 1'b0); n++)
    begin
      @(negedge mclk_i);
      s = s | (line_oe_o === 1'b1);
    end
    rsp = u_mst.rx_q;
  endtask
  task automatic rd(input logic [7:0] nd, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n);
    run('{nd, fc, a[15:8], a[7:0], n[15:8], n[7:0]});
  endtask
  // Whole reply compared, CRC included
  task automatic expect_rsp(input mrs_tbq_t e);
    logic [15:0] c;
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check(32'(rsp.size()), 32'(e.size()));
    foreach (e[i]) if (i < rsp.size()) check(32'(rsp[i]), 32'(e[i]));
  endtask
  task automatic word1(input logic [7:0] nd, input logic [15:0] a, input logic [15:0] w);
    rd(nd, 8'h04, a, 16'h0001);
    expect_rsp('{nd, 8'h04, 8'h02, w[15:8], w[7:0]});
  endtask
  // Bit inputs, each block with its two bits different
  task automatic t_bits();
    status_i.system_fault_bit = 1'b1;
    status_i.catchpot_full_bit = 1'b1;
    rd(8'h01, 8'h02, 16'h0000, 16'h0002);
    expect_rsp('{8'h01, 8'h02, 8'h01, 8'h01});
    rd(8'h01, 8'h02, 16'h0010, 16'h0002);
    expect_rsp('{8'h01, 8'h02, 8'h01, 8'h02});
  endtask
  // Every run code, every named sample point code and code 4, one combined alarm state
  task automatic t_codes();
    logic [15:0] sp[7] = '{16'h0000, 16'h0004, 16'hffff, 16'h0101, 16'hff01, 16'hac02, 16'hacff};
    for (int k = 0; k < 5; k++)
    begin
      status_i.run_state_word = 16'(k);
      word1(8'h01, 16'h0000, 16'(k));
    end
    foreach (sp[k])
    begin
      status_i.active_sample_point = sp[k];
      word1(8'h01, 16'h0030, sp[k]);
    end
    status_i.first_alarm_state = 16'h000c;
    word1(8'h01, 16'h0200, 16'h000c);
  endtask
  // Clock block by function 03, service block by 04
  task automatic t_words();
    logic [15:0] v[9] = '{16'h07e0, 16'h000c, 16'h001f, 16'h0017, 16'h003b, 16'h0000, 16'h07ee, 16'h0001, 16'h0009};
    mrs_tbq_t e;
    foreach (v[i])
      if (i < 6)
        status_i.clock_words[i] = v[i];
      else
        status_i.service_due_words[i - 6] = v[i];
    rd(8'h01, 8'h03, 16'h0020, 16'h0006);
    e = '{8'h01, 8'h03, 8'h0c};
    for (int i = 0; i < 6; i++) e = {e, v[i][15:8], v[i][7:0]};
    expect_rsp(e);
    rd(8'h01, 8'h04, 16'h0080, 16'h0003);
    e = '{8'h01, 8'h04, 8'h06};
    for (int i = 6; i < 9; i++) e = {e, v[i][15:8], v[i][7:0]};
    expect_rsp(e);
  endtask
  // Unmapped or overrunning reads, a zero count, a write; word still intact
  task automatic t_refuse();
    rd(8'h01, 8'h04, 16'h0040, 16'h0001);
    expect_rsp('{8'h01, 8'h84, 8'h02});
    rd(8'h01, 8'h03, 16'h0020, 16'h0007);
    expect_rsp('{8'h01, 8'h83, 8'h02});
    rd(8'h01, 8'h04, 16'h0000, 16'h0000);
    expect_rsp('{8'h01, 8'h84, 8'h03});
    rd(8'h01, 8'h02, 16'h0002, 16'h0001);
    expect_rsp('{8'h01, 8'h82, 8'h02});
    run('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h09});
    expect_rsp('{8'h01, 8'h86, 8'h01});
    word1(8'h01, 16'h0000, 16'h0004);
  endtask
  // Node 2, odd parity, two stops, termination on; defaults back; mid-run reset
  task automatic t_cfg();
    int k;
    cfg_i = mrs_pkg::mrs_cfg_t'({8'h02, BC, mrs_pkg::PAR_ODD, 2'h3});
    cfg_load_i = 1'b1;
    u_mst.odd = 1'b1;
    @(negedge mclk_i);
    cfg_load_i = 1'b0;
    check(32'(term_en_o), 32'h0000_0001);
    k = frames_ok;
    rd(8'h01, 8'h04, 16'h0000, 16'h0001);
    check(32'(rsp.size()), 32'h0000_0000);
    check(32'(frames_ok - k), 32'h0000_0000);
    word1(8'h02, 16'h0000, 16'h0004);
    check(32'(frames_ok - k), 32'h0000_0001);
    cfg_i = mrs_pkg::mrs_cfg_t'({8'h01, BC, mrs_pkg::PAR_EVEN, 2'h0});
    cfg_load_i = 1'b1;
    u_mst.odd = 1'b0;
    @(negedge mclk_i);
    cfg_load_i = 1'b0;
    check(32'(term_en_o), 32'h0000_0000);
    // Reset while node 2 is loaded must bring the stock setup back
    cfg_i = mrs_pkg::mrs_cfg_t'({8'h02, BC, mrs_pkg::PAR_ODD, 2'h3});
    cfg_load_i = 1'b1;
    @(negedge mclk_i);
    cfg_load_i = 1'b0;
    rst_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    check(32'(cfg_o), 32'({8'h01, BC, mrs_pkg::PAR_EVEN, 2'h0}));
    check(32'(term_en_o), 32'h0000_0000);
    word1(8'h01, 16'h0000, 16'h0004);
  endtask
  initial
  begin
    rst_i = 1'b1;
    cfg_load_i = 1'b0;
    cfg_i = '0;
    status_i = '0;
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    check(32'(cfg_o), 32'({8'h01, BC, mrs_pkg::PAR_EVEN, 2'h0}));
    check(32'({term_en_o, line_oe_o, line_tx_o}), 32'h0000_0001);
    t_bits();
    t_codes();
    t_words();
    t_refuse();
    t_cfg();
    check(32'(u_mst.fmt_err), 32'h0000_0000);
    final_report();
  end
endmodule
